// File: core/dps_cfg.svh
`ifndef DPS_CFG_SVH
`define DPS_CFG_SVH
`define DPS_CLK_HZ 50000000
`define DPS_DATA_W 32
`define DPS_NQ 4
`define DPS_NSTAGE 9
`define DPS_WIN_SLOTS 16
`define DPS_SLOT_IDX_W 4
`define DPS_DELAY_MAX_MIN 60
`define DPS_DELAY_MIN_W 6
`define DPS_SEC_PER_MIN 60
`define DPS_TICK_HZ 1
`define DPS_THR_MIN 32'h0000_0001
`define DPS_THR_MAX 32'h0262_5A00
`define DPS_THR_DEF 32'h0000_2710
`define DPS_MIN_INIT 32'hFFFF_FFFF
`define DPS_ZERO 32'h0000_0000
`endif

// File: core/dps_demand.sv
`timescale 1ns/10ps
`include "dps_cfg.svh"
module dps_demand
    import dps_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clear_i,
    input wire logic slot_i,
    input wire window_mode_type mode_i,
    input wire logic [31:0] sample_i,
    output logic [31:0] demand_o
);
    localparam int unsigned SUM_W = `DPS_DATA_W + `DPS_SLOT_IDX_W;
    logic [31:0] ring [`DPS_WIN_SLOTS];
    logic [3:0] wr_ptr;
    logic [SUM_W-1:0] run_sum;
    logic [SUM_W-1:0] next_sum;
    logic [`DPS_WIN_SLOTS-1:0] filled;
    logic [31:0] oldest;

    // an empty slot counts as zero, so a restarted window needs no ring wipe
    assign oldest = filled[wr_ptr] ? ring[wr_ptr] : `DPS_ZERO;
    assign next_sum = run_sum + SUM_W'(sample_i) - SUM_W'(oldest);

    // slot occupancy, emptied by reset and by demand reset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            filled <= '0;
        end else if (clear_i) begin
            filled <= '0;
        end else if (slot_i) begin
            filled[wr_ptr] <= 1'b1;
        end
    end

    // ring of window slots; newest replaces oldest
    always_ff @(posedge clk_i) begin
        if (slot_i) begin
            ring[wr_ptr] <= clear_i ? `DPS_ZERO : sample_i;
        end
    end

    // running sum and pointer
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr <= 4'h0;
            run_sum <= '0;
        end else if (clear_i) begin
            wr_ptr <= 4'h0;
            run_sum <= '0;
        end else if (slot_i) begin
            wr_ptr <= wr_ptr + 4'h1;
            run_sum <= next_sum;
        end
    end

    // sliding refreshes every slot, fixed only at window wrap
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            demand_o <= `DPS_ZERO;
        end else if (clear_i) begin
            demand_o <= `DPS_ZERO;
        end else if (slot_i) begin
            if (mode_i == sliding_window_type_e) begin
                demand_o <= next_sum[SUM_W-1:`DPS_SLOT_IDX_W];
            end else if (wr_ptr == 4'(`DPS_WIN_SLOTS - 1)) begin
                demand_o <= next_sum[SUM_W-1:`DPS_SLOT_IDX_W];
            end
        end
    end
endmodule : dps_demand

// File: core/dps_pkg.sv
package dps_pkg;
    typedef logic [31:0] value_type;
    typedef enum logic {fixed_window_type_e, sliding_window_type_e} window_mode_type;
    typedef enum logic {trig_duration} trigger_type;
    typedef struct packed {
        logic alarm_enable;
        logic block_allow;
        logic [5:0] delay_min;
        logic [31:0] threshold;
    } stage_cfg_type;
    typedef struct packed {
        logic [31:0] current;
        logic [31:0] active;
        logic [31:0] reactive;
        logic [31:0] apparent;
    } quantity_type;
    typedef struct packed {
        logic [31:0] value;
        logic [31:0] stamp;
    } peak_type;
endpackage : dps_pkg

// File: core/dps_stage.sv
`timescale 1ns/10ps
`include "dps_cfg.svh"
module dps_stage
    import dps_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic enable_i,
    input wire logic minute_i,
    input wire logic [31:0] value_i,
    input wire stage_cfg_type cfg_i,
    output logic alarm_o,
    output logic trip_o
);
    logic [5:0] minutes;
    logic excess;
    logic [5:0] delay_sat;

    // clamp delay to sixty minutes and compare in primary units
    assign delay_sat = (cfg_i.delay_min > 6'(`DPS_DELAY_MAX_MIN)) ?
        6'(`DPS_DELAY_MAX_MIN) : cfg_i.delay_min;
    assign excess = enable_i && (value_i > cfg_i.threshold);

    // persistence timer in minutes
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            minutes <= 6'h00;
        end else if (!excess) begin
            minutes <= 6'h00;
        end else if (minute_i && minutes < delay_sat) begin
            minutes <= minutes + 6'h01;
        end
    end

    // alarm on excess when enabled; trip once the delay elapsed
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            alarm_o <= 1'b0;
            trip_o <= 1'b0;
        end else begin
            alarm_o <= excess && cfg_i.alarm_enable;
            trip_o <= excess && (minutes >= delay_sat);
        end
    end
endmodule : dps_stage

// File: core/dps_top.sv
`timescale 1ns/10ps
`include "dps_cfg.svh"
module dps_top
    import dps_pkg::*;
#(
    parameter int unsigned TICKS_PER_SEC = `DPS_CLK_HZ / `DPS_TICK_HZ
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic plan_use_i,
    input wire logic function_active_i,
    input wire logic block_assigned_i,
    input wire logic block_pin_i,
    input wire logic sample_valid_i,
    input wire quantity_type sample_i,
    input wire logic [31:0] thd_current_i,
    input wire logic [31:0] thd_voltage_i,
    input wire logic [31:0] time_now_i,
    input wire trigger_type trigger_i,
    input wire logic [15:0] window_sec_i,
    input wire window_mode_type window_mode_i,
    input wire logic demand_reset_pin_i,
    input wire logic minmax_reset_pin_i,
    input wire stage_cfg_type stage_cfg_i [`DPS_NSTAGE],
    output logic active_o,
    output logic external_block_status_o,
    output quantity_type demand_o,
    output quantity_type min_o,
    output quantity_type max_o,
    output peak_type peak_o [`DPS_NQ],
    output logic [`DPS_NSTAGE-1:0] alarm_o,
    output logic [`DPS_NSTAGE-1:0] trip_o
);
    logic [1:0] blk_sync, drst_sync, mrst_sync;
    logic run;
    logic [31:0] sec_cnt;
    logic sec_tick, minute_tick, slot_tick;
    logic [5:0] sec_in_min;
    logic [15:0] slot_sec;
    logic [15:0] slot_len;
    logic [31:0] q_in [`DPS_NQ];
    logic [31:0] dem [`DPS_NQ];
    logic [31:0] mins [`DPS_NQ];
    logic [31:0] maxs [`DPS_NQ];
    logic [31:0] stage_val [`DPS_NSTAGE];
    logic [`DPS_NSTAGE-1:0] stage_en;
    logic [31:0] held_q [`DPS_NQ];
    stage_cfg_type peak_p_cfg;

    // two-flop synchronisers for pin inputs
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            blk_sync <= 2'h0;
            drst_sync <= 2'h0;
            mrst_sync <= 2'h0;
        end else begin
            blk_sync <= {blk_sync[0], block_pin_i};
            drst_sync <= {drst_sync[0], demand_reset_pin_i};
            mrst_sync <= {mrst_sync[0], minmax_reset_pin_i};
        end
    end

    // block only exists with planning use and activation
    assign run = plan_use_i && function_active_i;
    assign active_o = run;
    assign external_block_status_o = run && block_assigned_i && blk_sync[1];

    // second and minute tick generation
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sec_cnt <= `DPS_ZERO;
            sec_in_min <= 6'h00;
        end else if (sec_tick) begin
            sec_cnt <= `DPS_ZERO;
            sec_in_min <= minute_tick ? 6'h00 : sec_in_min + 6'h01;
        end else begin
            sec_cnt <= sec_cnt + 32'h0000_0001;
        end
    end
    assign sec_tick = (sec_cnt == 32'(TICKS_PER_SEC - 1));
    assign minute_tick = sec_tick && (sec_in_min == 6'(`DPS_SEC_PER_MIN - 1));

    // window slot timing: window split into equal slots, duration trigger
    assign slot_len = (window_sec_i >> `DPS_SLOT_IDX_W) == 16'h0000 ? 16'h0001 :
        (window_sec_i >> `DPS_SLOT_IDX_W);
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            slot_sec <= 16'h0000;
        end else if (drst_sync[1]) begin
            slot_sec <= 16'h0000;
        end else if (sec_tick) begin
            slot_sec <= slot_tick ? 16'h0000 : slot_sec + 16'h0001;
        end
    end
    assign slot_tick = sec_tick && (trigger_i == trig_duration) &&
        (slot_sec >= slot_len - 16'h0001);

    assign q_in[0] = sample_i.current;
    assign q_in[1] = sample_i.active;
    assign q_in[2] = sample_i.reactive;
    assign q_in[3] = sample_i.apparent;

    // per-quantity demand, peak, min and max
    genvar gq;
    generate
        for (gq = 0; gq < `DPS_NQ; gq++) begin : g_q
            // last valid sample; the bus is not trusted between strobes
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    held_q[gq] <= `DPS_ZERO;
                end else if (sample_valid_i) begin
                    held_q[gq] <= q_in[gq];
                end
            end
            dps_demand u_dem (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .clear_i(drst_sync[1]),
                .slot_i(slot_tick),
                .mode_i(window_mode_i),
                .sample_i(held_q[gq]),
                .demand_o(dem[gq])
            );
            // peak demand with timestamp
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    peak_o[gq] <= '0;
                end else if (drst_sync[1]) begin
                    peak_o[gq] <= '0;
                end else if (dem[gq] > peak_o[gq].value) begin
                    peak_o[gq].value <= dem[gq];
                    peak_o[gq].stamp <= time_now_i;
                end
            end
            // running min and max
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    mins[gq] <= `DPS_MIN_INIT;
                    maxs[gq] <= `DPS_ZERO;
                end else if (mrst_sync[1]) begin
                    mins[gq] <= `DPS_MIN_INIT;
                    maxs[gq] <= `DPS_ZERO;
                end else if (sample_valid_i) begin
                    if (q_in[gq] < mins[gq]) begin
                        mins[gq] <= q_in[gq];
                    end
                    if (q_in[gq] > maxs[gq]) begin
                        maxs[gq] <= q_in[gq];
                    end
                end
            end
        end
    endgenerate

    assign demand_o = {dem[0], dem[1], dem[2], dem[3]};
    assign min_o = {mins[0], mins[1], mins[2], mins[3]};
    assign max_o = {maxs[0], maxs[1], maxs[2], maxs[3]};

    // stage order: peak P,Q,S; demand P,Q,S; demand I; THD I; THD V
    assign stage_val[0] = held_q[1];
    assign stage_val[1] = held_q[2];
    assign stage_val[2] = held_q[3];
    assign stage_val[3] = dem[1];
    assign stage_val[4] = dem[2];
    assign stage_val[5] = dem[3];
    assign stage_val[6] = dem[0];
    assign stage_val[7] = thd_current_i;
    assign stage_val[8] = thd_voltage_i;

    // peak active power threshold kept inside its settable range
    always_comb begin
        peak_p_cfg = stage_cfg_i[0];
        if (stage_cfg_i[0].threshold < `DPS_THR_MIN) begin
            peak_p_cfg.threshold = `DPS_THR_MIN;
        end else if (stage_cfg_i[0].threshold > `DPS_THR_MAX) begin
            peak_p_cfg.threshold = `DPS_THR_MAX;
        end
    end

    // per-stage supervision with block gating
    genvar gs;
    generate
        for (gs = 0; gs < `DPS_NSTAGE; gs++) begin : g_s
            assign stage_en[gs] = run &&
                !(external_block_status_o && stage_cfg_i[gs].block_allow);
            dps_stage u_stage (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .enable_i(stage_en[gs]),
                .minute_i(minute_tick),
                .value_i(stage_val[gs]),
                .cfg_i((gs == 0) ? peak_p_cfg : stage_cfg_i[gs]),
                .alarm_o(alarm_o[gs]),
                .trip_o(trip_o[gs])
            );
        end
    endgenerate
endmodule : dps_top

// File: testbench/dps_front_model.sv
`timescale 1ns/10ps
module dps_front_model
    import dps_pkg::*;
(
    input wire logic clk_i,
    input wire logic run_i,
    input wire quantity_type level_i,
    output logic sample_valid_o,
    output quantity_type sample_o
);
    quantity_type last = '0;
    // remember the last delivered sample
    always @(posedge clk_i) begin
        if (run_i) begin
            last <= level_i;
        end
    end
    // between samples the bus shows garbage, not the old value
    assign sample_valid_o = run_i;
    assign sample_o = run_i ? level_i : ~last;
endmodule : dps_front_model

// File: testbench/dps_props.sv
`timescale 1ns/10ps
`include "dps_cfg.svh"
module dps_props
    import dps_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic plan_use_i,
    input wire logic function_active_i,
    input wire logic block_assigned_i,
    input wire logic sample_valid_i,
    input wire quantity_type sample_i,
    input wire logic [31:0] thd_voltage_i,
    input wire logic [31:0] time_now_i,
    input wire logic demand_reset_pin_i,
    input wire logic minmax_reset_pin_i,
    input wire stage_cfg_type stage_cfg_i [`DPS_NSTAGE],
    input wire logic active_o,
    input wire logic external_block_status_o,
    input wire quantity_type demand_o,
    input wire quantity_type min_o,
    input wire quantity_type max_o,
    input wire peak_type peak_o [`DPS_NQ],
    input wire logic [`DPS_NSTAGE-1:0] alarm_o,
    input wire logic [`DPS_NSTAGE-1:0] trip_o
);
    logic [2:0] mr_h;
    logic [2:0] dr_h;
    logic mr_quiet;
    logic dr_quiet;
    logic thd_hi;
    // reset pin history spanning the two-flop synchroniser
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mr_h <= 3'h0;
            dr_h <= 3'h0;
        end else begin
            mr_h <= {mr_h[1:0], minmax_reset_pin_i};
            dr_h <= {dr_h[1:0], demand_reset_pin_i};
        end
    end
    // quiet windows and voltage distortion excess on an unblockable stage
    assign mr_quiet = (mr_h == 3'h0) && !minmax_reset_pin_i;
    assign dr_quiet = (dr_h == 3'h0) && !demand_reset_pin_i;
    assign thd_hi = active_o && stage_cfg_i[8].alarm_enable && !stage_cfg_i[8].block_allow
        && (thd_voltage_i > stage_cfg_i[8].threshold);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_min_update: assert property (sample_valid_i && mr_quiet && sample_i.current < min_o.current
        |=> min_o.current == $past(sample_i.current)) else $error("min not taken");
    a_max_update: assert property (sample_valid_i && mr_quiet && sample_i.active > max_o.active
        |=> max_o.active == $past(sample_i.active)) else $error("max not taken");
    a_minmax_hold: assert property (!sample_valid_i && mr_quiet
        |=> $stable(min_o) && $stable(max_o)) else $error("min max moved");
    a_minmax_clear: assert property ((&mr_h) && minmax_reset_pin_i
        |=> (&min_o) && max_o == '0) else $error("min max not cleared");
    a_active_level: assert property (active_o == (plan_use_i && function_active_i))
        else $error("active wrong");
    a_inactive_quiet: assert property (!active_o && !$past(active_o)
        |-> alarm_o == '0 && trip_o == '0) else $error("output while off");
    a_thd_alarm: assert property (thd_hi |=> alarm_o[8]) else $error("no thd alarm");
    a_thd_trip: assert property (thd_hi && stage_cfg_i[8].delay_min == 6'h00
        |=> trip_o[8]) else $error("no thd trip");
    a_thd_clear: assert property (thd_voltage_i <= stage_cfg_i[8].threshold
        |=> !alarm_o[8] && !trip_o[8]) else $error("thd flag stuck");
    a_block_stage: assert property (external_block_status_o && block_assigned_i
        && stage_cfg_i[7].block_allow |=> !alarm_o[7] && !trip_o[7]) else $error("not blocked");
    a_peak_above: assert property (dr_quiet |=> peak_o[1].value >= $past(demand_o.active))
        else $error("peak below demand");
    a_peak_stamp: assert property (dr_quiet && $changed(peak_o[1].value)
        |-> peak_o[1].stamp == $past(time_now_i)) else $error("bad stamp");
    a_peak_clear: assert property ((&dr_h) && demand_reset_pin_i
        |=> peak_o[1] == '0 && peak_o[0] == '0) else $error("peak not cleared");
    c_thd_trip: cover property (alarm_o[8] && trip_o[8]);
    c_delay_trip: cover property ($rose(trip_o[7]));
    c_peak_set: cover property (peak_o[1].value != 32'h0000_0000);
endmodule : dps_props
bind dps_top dps_props i_dps_props (.clk_i, .rst_i, .plan_use_i, .function_active_i,
    .block_assigned_i, .sample_valid_i, .sample_i, .thd_voltage_i, .time_now_i,
    .demand_reset_pin_i, .minmax_reset_pin_i, .stage_cfg_i, .active_o,
    .external_block_status_o, .demand_o, .min_o, .max_o, .peak_o, .alarm_o, .trip_o);

// File: testbench/tb.sv
`timescale 1ns/10ps
`include "dps_cfg.svh"
module tb;
    import dps_pkg::*;
    logic clk_i = 0, rst_i = 1, plan_use_i = 0, function_active_i = 0, run = 0;
    logic block_assigned_i = 0, block_pin_i = 0, demand_reset_pin_i = 0, minmax_reset_pin_i = 0;
    logic sample_valid_i, active_o, external_block_status_o;
    logic [31:0] thd_current_i = 0, thd_voltage_i = 0, time_now_i = 32'h0000_1234;
    window_mode_type window_mode_i = fixed_window_type_e;
    quantity_type level = '0, sample_i, demand_o, min_o, max_o;
    stage_cfg_type stage_cfg_i [`DPS_NSTAGE];
    peak_type peak_o [`DPS_NQ];
    logic [8:0] alarm_o, trip_o;
    int fail_count = 0, checks = 0, n;
    dps_front_model i_dps_front_model (.clk_i, .run_i(run), .level_i(level),
        .sample_valid_o(sample_valid_i), .sample_o(sample_i));
    dps_top #(.TICKS_PER_SEC(10)) i_dps_top (.clk_i, .rst_i, .plan_use_i, .function_active_i,
        .block_assigned_i, .block_pin_i, .sample_valid_i, .sample_i, .thd_current_i,
        .thd_voltage_i, .time_now_i, .trigger_i(trig_duration), .window_sec_i(16'h0010),
        .window_mode_i, .demand_reset_pin_i, .minmax_reset_pin_i, .stage_cfg_i, .active_o,
        .external_block_status_o, .demand_o, .min_o, .max_o, .peak_o, .alarm_o, .trip_o);
    // 50 MHz clock
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic waitn(input int k);
        repeat (k) @(negedge clk_i);
    endtask : waitn
    task automatic send(input logic [31:0] v);
        level = {4{v}};
        run = 1;
        waitn(1);
        run = 0;
        waitn(1);
    endtask : send
    task automatic close_out();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    // watchdog against a hung run
    initial begin
        #400000;
        fail_count++;
        close_out();
    end
    // main sequence
    initial begin
        foreach (stage_cfg_i[k]) stage_cfg_i[k] = {1'b1, 1'b0, 6'h00, 32'h0000_2710};
        waitn(10);
        rst_i = 0;
        waitn(1);
        check(min_o.current, 32'hFFFF_FFFF);
        check(max_o.active, 0);
        plan_use_i = 1;
        thd_voltage_i = 32'h0000_3000;
        thd_current_i = 32'h0000_2711;
        waitn(3);
        check(active_o, 0);
        check(alarm_o, 0);
        plan_use_i = 0;
        function_active_i = 1;
        waitn(3);
        check(active_o, 0);
        check(trip_o, 0);
        plan_use_i = 1;
        waitn(2);
        check(alarm_o, 9'h180);
        check(trip_o, 9'h180);
        thd_voltage_i = 32'h0000_2710;
        waitn(2);
        check(alarm_o[8], 0);
        stage_cfg_i[8].alarm_enable = 0;
        thd_voltage_i = 32'h0000_3000;
        waitn(2);
        check(alarm_o[8], 0);
        stage_cfg_i[8].alarm_enable = 1;
        stage_cfg_i[7].block_allow = 1;
        block_assigned_i = 1;
        block_pin_i = 1;
        waitn(4);
        check(external_block_status_o, 1);
        check(alarm_o[8:7], 2'b10);
        block_assigned_i = 0;
        waitn(4);
        check(alarm_o[7], 1);
        block_pin_i = 0;
        thd_current_i = 0;
        waitn(2);
        stage_cfg_i[7].delay_min = 6'h01;
        thd_current_i = 32'h0000_3000;
        waitn(2);
        check(alarm_o[7], 1);
        check(trip_o[7], 0);
        for (n = 0; n < 1300 && trip_o[7] !== 1'b1; n++) waitn(1);
        check(trip_o[7], 1);
        thd_current_i = 0;
        waitn(2);
        check({alarm_o[7], trip_o[7]}, 0);
        send(32'h0000_0064);
        send(32'h0000_0032);
        send(32'h0000_00C8);
        check(min_o.current, 32'h0000_0032);
        check(max_o.reactive, 32'h0000_00C8);
        minmax_reset_pin_i = 1;
        waitn(6);
        minmax_reset_pin_i = 0;
        waitn(4);
        check(min_o.apparent, 32'hFFFF_FFFF);
        check(max_o.current, 0);
        send(32'h0000_0040);
        check(min_o.active, 32'h0000_0040);
        demand_reset_pin_i = 1;
        waitn(6);
        demand_reset_pin_i = 0;
        level = {4{32'h0000_0100}};
        run = 1;
        waitn(80);
        check(demand_o.active, 0);
        waitn(100);
        check(demand_o.active, 32'h0000_0100);
        check(demand_o.current, 32'h0000_0100);
        demand_reset_pin_i = 1;
        window_mode_i = sliding_window_type_e;
        waitn(6);
        demand_reset_pin_i = 0;
        waitn(40);
        check(demand_o.reactive != 0, 1);
        for (n = 0; n < 7; n++) stage_cfg_i[n].threshold = 32'h0000_0080;
        waitn(170);
        check(demand_o.apparent, 32'h0000_0100);
        check(alarm_o[6:0], 7'h7F);
        check(peak_o[1].value, 32'h0000_0100);
        check(peak_o[0].stamp, 32'h0000_1234);
        time_now_i = 32'h0000_5678;
        level = {4{32'h0000_0080}};
        waitn(170);
        check(peak_o[1].value, 32'h0000_0100);
        check(peak_o[1].stamp, 32'h0000_1234);
        demand_reset_pin_i = 1;
        waitn(6);
        check(peak_o[1].value, 0);
        check(peak_o[0].stamp, 0);
        stage_cfg_i[0].threshold = 32'hFFFF_FFFF;
        level = {4{32'h0300_0000}};
        waitn(2);
        check(alarm_o[0], 1);
        demand_reset_pin_i = 0;
        run = 0;
        waitn(2);
        close_out();
    end
endmodule : tb
